// file: hw/i2c_restart_status.sv
// Two-wire bus slave that reports a status byte at each interrupt point,
// including transfers with repeated start and extension codes.
// Assumes open-drain pins resolved outside and a reader on the event port.
// Operation
// - Address match with acknowledge posts status 0001X110, also after repeated start.
// - Eighth-clock wait: each data byte after address match posts 0001X000.
// - Ninth-clock wait: data byte posts 0001XX00 after its acknowledge.
// - Eighth-clock wait: data byte after extension code posts 0010X000.
// - Ninth-clock wait: extension code acknowledge posts 0010X110.
// - Ninth-clock wait: data byte after extension code posts 0010XX00.
// - Stop posts 00000001 only when stop interrupt enabled; others always.
`include "i2c_restart_consts.svh"
module i2c_restart_status
  import i2c_restart_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic wait_timing_select,
  input wire logic stop_irq_enable,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic status_valid,
  input wire logic status_ready,
  output event_t bus_status_byte
);

  // Reset release in each domain
  logic [1:0] srst_q;
  logic [1:0] lrst_q;
  logic srst_n;
  logic lrst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      srst_q <= 2'b00;
    end else begin
      srst_q <= {srst_q[0], 1'b1};
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  assign srst_n = srst_q[1];
  assign lrst_n = lrst_q[1];

  // Link-side input synchronisers with agreement filter
  logic ack_tgl_r;
  logic [`LSYNC_N-1:0] lraw;
  logic [`LSYNC_N-1:0] lval;
  assign lraw = {ack_tgl_r, stop_irq_enable, wait_timing_select, sda_in, scl_in};
  localparam logic [`LSYNC_N-1:0] lsync_init = `LSYNC_RST;

  for (genvar i = 0; i < `LSYNC_N; i++) begin : g_lsync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic val_r;
    always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
        s1_r <= lsync_init[i];
        s2_r <= lsync_init[i];
        s3_r <= lsync_init[i];
        val_r <= lsync_init[i];
      end else begin
        s1_r <= lraw[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          val_r <= s3_r;
        end
      end
    end
    assign lval[i] = val_r;
  end

  logic scl_f;
  logic sda_f;
  logic wtim_f;
  logic spie_f;
  logic ack_f;
  assign {ack_f, spie_f, wtim_f, sda_f, scl_f} = lval;

  // Bus condition detection
  logic scl_q;
  logic sda_q;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign rise = scl_f && !scl_q;
  assign fall = !scl_f && scl_q;
  assign start_det = scl_f && scl_q && sda_q && !sda_f;
  assign stop_det = scl_f && scl_q && !sda_q && sda_f;

  // Byte receiver state
  link_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic addressed_r;
  logic exc_r;
  logic trc_r;
  logic match_r;
  logic from_addr_r;
  logic ack_seen_r;
  logic byte_done;
  logic addr_hit;
  logic ext_hit;

  assign byte_done = (cnt_r == `BYTE_BITS);
  assign addr_hit = (shift_r[7:1] == `SLAVE_ADDR);
  assign ext_hit = (shift_r[7:3] == `EXT_PREFIX);

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_r <= L_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      addressed_r <= 1'b0;
      exc_r <= 1'b0;
      trc_r <= 1'b0;
      match_r <= 1'b0;
      from_addr_r <= 1'b0;
      ack_seen_r <= 1'b0;
    end else if (start_det) begin
      state_r <= L_ADDR;
      cnt_r <= 4'h0;
      addressed_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= L_IDLE;
      addressed_r <= 1'b0;
    end else if (rise) begin
      if (state_r == L_ADDR || state_r == L_DATA) begin
        shift_r <= {shift_r[6:0], sda_f};
        cnt_r <= 4'(cnt_r + 4'h1);
      end else if (state_r == L_ACK) begin
        ack_seen_r <= !sda_f;
      end
    end else if (fall) begin
      case (state_r)
        L_ADDR: begin
          if (byte_done && (addr_hit || ext_hit)) begin
            state_r <= L_ACK;
            addressed_r <= 1'b1;
            exc_r <= ext_hit;
            trc_r <= shift_r[0] && !ext_hit;
            match_r <= addr_hit && !ext_hit;
            from_addr_r <= 1'b1;
          end else if (byte_done) begin
            state_r <= L_SKIP;
          end
        end
        L_DATA: begin
          if (byte_done) begin
            state_r <= L_ACK;
            from_addr_r <= 1'b0;
          end
        end
        L_ACK: begin
          state_r <= L_DATA;
          cnt_r <= 4'h0;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Acknowledge drive on the ninth clock
  logic sda_drv_r;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sda_drv_r <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_drv_r <= 1'b0;
    end else if (fall) begin
      if (state_r == L_ADDR && byte_done) begin
        sda_drv_r <= addr_hit || ext_hit;
      end else if (state_r == L_DATA && byte_done) begin
        sda_drv_r <= !trc_r;
      end else begin
        sda_drv_r <= 1'b0;
      end
    end
  end

  // Status byte composition
  function automatic logic [7:0] mk_status(input logic exc, input logic trc,
                                           input logic ackd, input logic std);
    logic [7:0] st;
    st = 8'h00;
    st[`ST_EXC] = exc;
    st[`ST_COI] = !exc;
    st[`ST_TRC] = trc;
    st[`ST_ACKD] = ackd;
    st[`ST_STD] = std;
    return st;
  endfunction

  logic post_v;
  logic [7:0] post_st;

  always_comb begin
    post_v = 1'b0;
    post_st = 8'h00;
    if (stop_det) begin
      if (addressed_r && spie_f) begin
        post_v = 1'b1;
        post_st[`ST_SPD] = 1'b1;
      end
    end else if (fall) begin
      if (state_r == L_ADDR && byte_done && ext_hit) begin
        post_v = 1'b1;
        post_st = mk_status(1'b1, 1'b0, 1'b0, 1'b1);
      end else if (state_r == L_DATA && byte_done && !wtim_f) begin
        post_v = 1'b1;
        post_st = mk_status(exc_r, trc_r, 1'b0, 1'b0);
      end else if (state_r == L_ACK && from_addr_r && match_r) begin
        post_v = 1'b1;
        post_st = mk_status(1'b0, trc_r, 1'b1, 1'b1);
      end else if (state_r == L_ACK && from_addr_r && exc_r && wtim_f) begin
        post_v = 1'b1;
        post_st = mk_status(1'b1, 1'b0, 1'b1, 1'b1);
      end else if (state_r == L_ACK && !from_addr_r && wtim_f) begin
        post_v = 1'b1;
        post_st = mk_status(exc_r, trc_r, ack_seen_r, 1'b0);
      end
    end
  end

  // Event hold, crossing request and clock stretch
  event_t ev_r;
  logic pend_r;
  logic req_tgl_r;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ev_r <= '0;
      pend_r <= 1'b0;
      req_tgl_r <= 1'b0;
    end else if (post_v && !pend_r) begin
      ev_r <= '{status: post_st, data: shift_r};
      pend_r <= 1'b1;
      req_tgl_r <= !req_tgl_r;
    end else if (pend_r && ack_f == req_tgl_r) begin
      pend_r <= 1'b0;
    end
  end

  assign scl_oe = pend_r && !ev_r.status[`ST_SPD];
  assign scl_out = 1'b0;
  assign sda_oe = sda_drv_r;
  assign sda_out = 1'b0;

  // System side: request synchroniser, acknowledge toggle, buffer
  logic rq1_r;
  logic rq2_r;
  logic rq3_r;
  logic req_f;
  logic buf_ready;
  logic push;

  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      rq1_r <= 1'b0;
      rq2_r <= 1'b0;
      rq3_r <= 1'b0;
      req_f <= 1'b0;
    end else begin
      rq1_r <= req_tgl_r;
      rq2_r <= rq1_r;
      rq3_r <= rq2_r;
      if (rq2_r == rq3_r) begin
        req_f <= rq3_r;
      end
    end
  end

  assign push = (req_f != ack_tgl_r) && buf_ready;

  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      ack_tgl_r <= 1'b0;
    end else begin
      ack_tgl_r <= ack_tgl_r ^ push;
    end
  end

  event_buffer u_buf (
    .clock(clock),
    .rst_n(srst_n),
    .in_valid(req_f != ack_tgl_r),
    .in_ready(buf_ready),
    .in_word(ev_r),
    .out_valid(status_valid),
    .out_ready(status_ready),
    .out_word(bus_status_byte)
  );

  // Checks
  addr_ack_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_ACK && from_addr_r && match_r && !pend_r
    |=> pend_r && (ev_r.status & `MASK_X) == `ST_ADDR_ACK)
    else $error("address match status wrong");
  data_w8_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_DATA && byte_done && !wtim_f && !exc_r && !pend_r
    |=> pend_r && (ev_r.status & `MASK_X) == `ST_DATA_W8 ##1 scl_oe)
    else $error("eighth clock data status wrong");
  data_w9_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_ACK && !from_addr_r && wtim_f && !exc_r && !pend_r
    |=> pend_r && (ev_r.status & `MASK_XX) == `ST_DATA_W9)
    else $error("ninth clock data status wrong");
  ext_w8_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_DATA && byte_done && !wtim_f && exc_r && !pend_r
    |=> (ev_r.status & `MASK_X) == `ST_EXT_W8)
    else $error("extension data status wrong");
  ext_ack_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_ACK && from_addr_r && exc_r && wtim_f && !pend_r
    |=> $changed(req_tgl_r) && (ev_r.status & `MASK_X) == `ST_EXT_ACK)
    else $error("extension acknowledge status wrong");
  ext_w9_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_ACK && !from_addr_r && wtim_f && exc_r && !pend_r
    |=> (ev_r.status & `MASK_XX) == `ST_EXT_W9)
    else $error("extension ninth clock status wrong");
  stop_on_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    stop_det && addressed_r && spie_f && !pend_r
    |=> ev_r.status == `ST_STOP && !scl_oe)
    else $error("stop status missing");
  stop_off_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    stop_det && !spie_f |=> $stable(req_tgl_r))
    else $error("stop event without enable");
  wait_place_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fall && state_r == L_DATA && byte_done && wtim_f && !pend_r |=> !pend_r && !scl_oe)
    else $error("event at eighth clock under ninth clock wait");

  restart_c: cover property (@(posedge link_clk) disable iff (!lrst_n)
    start_det && state_r == L_DATA);
  ext_c: cover property (@(posedge link_clk) disable iff (!lrst_n)
    post_v && post_st[`ST_EXC]);
  stop_c: cover property (@(posedge link_clk) disable iff (!lrst_n)
    post_v && post_st[`ST_SPD]);

endmodule

// file: hw/i2c_restart_consts.svh
// Constants for the slave status reporter: byte layout, status fields, codes.
// Assumes inclusion by bare name from design files that need these numbers.
`ifndef I2C_RESTART_CONSTS_SVH
`define I2C_RESTART_CONSTS_SVH

// Own slave address and extension code prefix
`define SLAVE_ADDR 7'h3a
`define EXT_PREFIX 5'h1e

// Bits in one byte on the wire
`define BYTE_BITS 4'h8

// Status byte field positions
`define ST_EXC 5
`define ST_COI 4
`define ST_TRC 3
`define ST_ACKD 2
`define ST_STD 1
`define ST_SPD 0

// Expected status patterns and don't-care masks
`define MASK_X 8'hf7
`define MASK_XX 8'hf3
`define ST_ADDR_ACK 8'h16
`define ST_DATA_W8 8'h10
`define ST_DATA_W9 8'h10
`define ST_EXT_W8 8'h20
`define ST_EXT_ACK 8'h26
`define ST_EXT_W9 8'h20
`define ST_STOP 8'h01

// Reset values of link-side synchroniser lanes: {ack, stop_en, wait, sda, scl}
`define LSYNC_RST 5'h03
`define LSYNC_N 5

`endif

// file: hw/i2c_restart_pkg.sv
// Types shared by the slave status reporter and its event buffer.
// Assumes nothing beyond a SystemVerilog compiler.
package i2c_restart_pkg;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] data;
  } event_t;

  typedef enum logic [4:0] {
    L_IDLE = 5'h01,
    L_ADDR = 5'h02,
    L_DATA = 5'h04,
    L_ACK = 5'h08,
    L_SKIP = 5'h10
  } link_state_t;

endpackage

// file: hw/event_buffer.sv
// Two-entry buffer of status events between the crossing and the reader.
// Assumes one clock and a reset already synchronised to it.
module event_buffer
  import i2c_restart_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input event_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output event_t out_word
);

  event_t mem_r [2];
  logic wr_r;
  logic rd_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_word = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wr_r] <= in_word;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wr_r <= wr_r ^ push;
      rd_r <= rd_r ^ pop;
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end

  buf_full_c: cover property (@(posedge clock) disable iff (!rst_n) cnt_r == 2'h2);

endmodule

// file: tb/i2c_master_model.sv
// Behavioural two-wire bus master that writes bytes to the slave.
// Assumes the bench resolves both open-drain lines with pull-ups.
module i2c_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic hung
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QUARTER = 100;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hung = 1'b0;
  end
  // Release clock, honour stretch, sample data once high
  task automatic rise(output logic s);
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (n >= 5000) hung = 1'b1;
    s = sda;
    #QUARTER;
  endtask
  task automatic put_bit(input logic b, output logic s);
    sda_low = !b;
    #QUARTER;
    rise(s);
    scl_low = 1'b1;
    #30;
  endtask
  task automatic start_cond();
    sda_low = 1'b1;
    #QUARTER;
    scl_low = 1'b1;
    #30;
  endtask
  task automatic restart_cond();
    logic s;
    sda_low = 1'b0;
    #QUARTER;
    rise(s);
    sda_low = 1'b1;
    #QUARTER;
    scl_low = 1'b1;
    #30;
  endtask
  task automatic stop_cond();
    logic s;
    sda_low = 1'b1;
    #QUARTER;
    rise(s);
    sda_low = 1'b0;
    #QUARTER;
  endtask
  // Eight bits MSB first, then the acknowledge bit from the slave
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, ack);
  endtask
endmodule

// file: tb/tb.sv
// Bench for the slave status reporter: repeated-start transfers, both waits.
// Assumes the master model on the far side and a reader that can stall.
`include "i2c_restart_consts.svh"
module tb;
  import i2c_restart_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, link_clk = 0, arst_n = 0, stall = 0, status_ready = 0;
  logic wait_timing_select = 0, stop_irq_enable = 0;
  logic scl_out, scl_oe, sda_out, sda_oe, status_valid, m_scl_low, m_sda_low, hung;
  event_t bus_status_byte;
  wire scl = !(m_scl_low || (scl_oe && !scl_out));
  wire sda = !(m_sda_low || (sda_oe && !sda_out));
  int bad_count = 0, samples_checked = 0;
  logic [7:0] got_q[$], exp_q[$], msk_q[$], got_d_q[$];
  always #5 clock = ~clock;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  i2c_restart_status i2c_restart_status_inst (.clock(clock), .arst_n(arst_n),
    .link_clk(link_clk), .wait_timing_select(wait_timing_select),
    .stop_irq_enable(stop_irq_enable), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .status_valid(status_valid),
    .status_ready(status_ready), .bus_status_byte(bus_status_byte));
  i2c_master_model i2c_master_model_inst (.scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low), .hung(hung));
  always @(negedge clock) status_ready <= !stall;
  always @(posedge clock) begin
    if (status_valid === 1'b1 && status_ready === 1'b1) begin
      got_q.push_back(bus_status_byte.status);
      got_d_q.push_back(bus_status_byte.data);
    end
  end
  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic expect_ev(input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask
  task automatic set_mode(input logic w, input logic s);
    @(negedge clock);
    wait_timing_select = w;
    stop_irq_enable = s;
    repeat (20) @(negedge clock);
  endtask
  // Address, data, repeated start, second address byte, data, stop
  task automatic transfer(input logic [7:0] second);
    logic a;
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.write_byte({`SLAVE_ADDR, 1'b0}, a);
    check(a === 1'b0, "address not acknowledged");
    i2c_master_model_inst.write_byte(8'h5c, a);
    check(a === 1'b0, "data not acknowledged");
    i2c_master_model_inst.restart_cond();
    i2c_master_model_inst.write_byte(second, a);
    check(a === 1'b0, "second address not acknowledged");
    i2c_master_model_inst.write_byte(8'ha3, a);
    check(a === 1'b0, "data not acknowledged");
    i2c_master_model_inst.stop_cond();
    check(hung === 1'b0, "clock held low too long");
  endtask
  task automatic judge(input string name);
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 3000) begin
      @(posedge clock);
      n++;
    end
    repeat (100) @(posedge clock);
    check(got_q.size() == exp_q.size(), "event count");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      check((got_q[i] & msk_q[i]) === exp_q[i], "status byte");
    end
    check(got_d_q.size() > 0 && got_d_q[0] === {`SLAVE_ADDR, 1'b0}, "address byte");
    check(got_d_q.size() > 1 && got_d_q[1] === 8'h5c, "data byte");
    got_q.delete();
    got_d_q.delete();
    exp_q.delete();
    msk_q.delete();
    $display("test %s done", name);
  endtask
  task automatic stall_reader();
    @(negedge clock);
    stall = 1'b1;
    fork
      begin
        #20000;
        @(negedge clock);
        stall = 1'b0;
      end
    join_none
  endtask
  task automatic addr_wait8();
    set_mode(1'b0, 1'b1);
    expect_ev(8'h16, 8'hf7);
    expect_ev(8'h10, 8'hf7);
    expect_ev(8'h16, 8'hf7);
    expect_ev(8'h10, 8'hf7);
    expect_ev(8'h01, 8'hff);
    transfer({`SLAVE_ADDR, 1'b0});
    judge("addr_wait8");
  endtask
  task automatic addr_wait9();
    set_mode(1'b1, 1'b0);
    stall_reader();
    expect_ev(8'h16, 8'hf7);
    expect_ev(8'h10, 8'hf3);
    expect_ev(8'h16, 8'hf7);
    expect_ev(8'h10, 8'hf3);
    transfer({`SLAVE_ADDR, 1'b0});
    judge("addr_wait9");
  endtask
  task automatic ext_wait8();
    set_mode(1'b0, 1'b1);
    expect_ev(8'h16, 8'hf7);
    expect_ev(8'h10, 8'hf7);
    expect_ev(8'h22, 8'hf7);
    expect_ev(8'h20, 8'hf7);
    expect_ev(8'h01, 8'hff);
    transfer(8'hf0);
    judge("ext_wait8");
  endtask
  task automatic ext_wait9();
    set_mode(1'b1, 1'b1);
    stall_reader();
    expect_ev(8'h16, 8'hf7);
    expect_ev(8'h10, 8'hf3);
    expect_ev(8'h22, 8'hf7);
    expect_ev(8'h26, 8'hf7);
    expect_ev(8'h20, 8'hf3);
    expect_ev(8'h01, 8'hff);
    transfer(8'hf0);
    judge("ext_wait9");
  endtask
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #900000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (20) @(negedge clock);
    addr_wait8();
    addr_wait9();
    ext_wait8();
    ext_wait9();
    complete_run();
  end
endmodule
